// File: hw/gbp_cfg.svh
/*
  Register map, field positions, reset values and timing constants of the graphic bus port.
  Assumes inclusion by its bare name from the design modules and the bench.
*/
`ifndef GBP_CFG_SVH
`define GBP_CFG_SVH

// ---------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------
`define GBP_CTRL_OFFS 8'h00
`define GBP_DATA_OFFS 8'h04
`define GBP_ADDR_W 8

// ---------------------------------------------
// Control register fields
// ---------------------------------------------
`define GBP_CTRL_RESET 8'h00
`define GBP_TIM_HI 7
`define GBP_TIM_LO 4
`define GBP_EN_BIT 3
`define GBP_BSY_BIT 2
`define GBP_SEQ_BIT 1
`define GBP_DTA_BIT 0

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define GBP_IO_DIV 4
`define GBP_RECOVERY_CYC 1

`endif

// File: hw/gbp_pkg.sv
/*
  Types shared by the graphic bus port modules.
  Assumes the constants header gbp_cfg.svh is on the include path.
*/
package gbp_pkg;
  typedef enum logic [2:0] {
    GBP_IDLE,
    GBP_WR_LOW,
    GBP_RD_LOW,
    GBP_RD_HOLD,
    GBP_RECOVER
  } gbp_phase_type;

  typedef enum logic [0:0] {
    GBP_DIR_WRITE,
    GBP_DIR_READ
  } gbp_dir_type;
endpackage

// File: hw/gbp_io_tick.sv
/*
  I/O clock tick generator: one-cycle pulse every DIV system clocks.
  Assumes clk at 125 MHz and an active high synchronous reset.
*/
`timescale 1ns/1ps
`include "gbp_cfg.svh"

module gbp_io_tick #(
  parameter int DIV = `GBP_IO_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } gbp_tick_state_type;

  gbp_tick_state_type st_reg;
  gbp_tick_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      // Restart one step past the wrap so the first tick lands DIV clocks after a restart
      st_next.cnt = (DIV > 1) ? 16'h0001 : 16'h0000;
    end else if (st_reg.cnt == 16'(DIV - 1)) begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick & ce;
endmodule

// File: hw/gbp_pin_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the pins are asynchronous to clk.
*/
`timescale 1ns/1ps

module gbp_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gbp_sync_state_type;

  gbp_sync_state_type st_reg;
  gbp_sync_state_type st_next;

  always_comb begin
    st_next.meta = pin_in;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pin_sync = st_reg.sync;
endmodule

// File: hw/gbp_graphic_port.sv
/*
  Graphic bus port: 8-bit parallel master towards an external display driver,
  control and data registers on AXI4-Lite, strobe timing from the I/O clock.
  Assumes a DMA controller that drives dma_done_interrupt and watches
  channel_dma_acknowledge; address lines come from a general-purpose port elsewhere.
*/
// The AXI4-Lite slave port was chosen for this implementation.
// How it works
// - Data write drives low and high nibble latches
// - Data read returns pins captured by last read cycle
// - Every data access pulses DMA acknowledge
// - Control 8 bits: timing, enable, flags
// - Timing period is 2^(n+1) I/O clocks
// - Enable bit gates the start of each strobe cycle
// - Busy set when access starts cycle, cleared at end
// - Sequence flag set by access, done clears
// - Transfer flag write-one set, done clears
// - Strobes stay high one I/O clock
// - One CPU write makes one bus cycle
// - Read after completion starts next read
// - Latches update even when port disabled
// - Final DMA pulse clears transfer flag
`timescale 1ns/1ps
`include "gbp_cfg.svh"

module gbp_graphic_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [`GBP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`GBP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_done_interrupt,
  output logic channel_dma_acknowledge,
  input wire logic [7:0] ext_data_in,
  output logic [3:0] low_nibble_port_latch,
  output logic [3:0] high_nibble_port_latch,
  output logic [7:0] ext_data_oe,
  output logic write_strobe_n,
  output logic read_strobe_n
);
  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef struct packed {
    logic [3:0] tim;
    logic en;
    logic cycle_busy_flag;
    logic seq;
    logic dma_transfer_active_flag;
    logic [7:0] latch;
    logic [7:0] rd_capt;
    gbp_pkg::gbp_phase_type phase;
    logic [16:0] cnt;
    logic aw_got;
    logic w_got;
    logic [`GBP_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic dma_acknowledge;
    logic drive;
    gbp_pkg::gbp_dir_type dir;
  } gbp_state_type;

  gbp_state_type st_reg;
  gbp_state_type st_next;

  logic io_tick;
  logic [7:0] pins_sync;
  logic wr_fire;
  logic rd_fire;
  logic data_wr;
  logic data_rd;
  logic cyc_start;

  function automatic logic hits(input logic [`GBP_ADDR_W-1:0] a, input logic [`GBP_ADDR_W-1:0] offs);
    hits = (a[`GBP_ADDR_W-1:2] == offs[`GBP_ADDR_W-1:2]);
  endfunction

  // Period in I/O ticks: 2^(n+1)
  function automatic logic [16:0] period_ticks(input logic [3:0] n);
    period_ticks = 17'h00001 << ({1'b0, n} + 5'h01);
  endfunction

  gbp_io_tick #(
    .DIV(`GBP_IO_DIV)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    // Divider restarts with each cycle, so strobe widths are whole I/O periods
    .run(st_reg.tim != 4'h0 && !cyc_start),
    .tick(io_tick)
  );

  gbp_pin_sync #(
    .W(8)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_in(ext_data_in),
    .pin_sync(pins_sync)
  );

  // ---------------------------------------------
  // AXI handshake decode
  // ---------------------------------------------
  assign s_axi_awready = ce & ~st_reg.aw_got & ~st_reg.bvalid;
  assign s_axi_wready = ce & ~st_reg.w_got & ~st_reg.bvalid;
  assign s_axi_arready = ce & ~st_reg.rvalid;
  assign wr_fire = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign data_wr = wr_fire & hits(st_reg.aw_addr, `GBP_DATA_OFFS) & st_reg.w_strb[0];
  assign data_rd = rd_fire & hits(s_axi_araddr, `GBP_DATA_OFFS);
  assign cyc_start = st_reg.en & (st_reg.tim != 4'h0) & (data_wr | data_rd);

  always_comb begin
    st_next = st_reg;
    st_next.dma_acknowledge = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // ---------------------------------------------
    // Strobe sequencer
    // ---------------------------------------------
    if (st_reg.tim == 4'h0) begin
      // Port logic stopped: strobes released, cycle abandoned
      st_next.phase = gbp_pkg::GBP_IDLE;
      st_next.drive = 1'b0;
    end else if (io_tick) begin
      case (st_reg.phase)
        gbp_pkg::GBP_IDLE: begin
        end
        gbp_pkg::GBP_WR_LOW, gbp_pkg::GBP_RD_LOW: begin
          if (st_reg.cnt <= 17'h00001) begin
            if (st_reg.phase == gbp_pkg::GBP_RD_LOW) begin
              st_next.rd_capt = pins_sync;
              // Read strobe held until the next data access
              st_next.phase = gbp_pkg::GBP_RD_HOLD;
              st_next.cycle_busy_flag = 1'b0;
            end else begin
              st_next.phase = gbp_pkg::GBP_RECOVER;
              st_next.cnt = 17'(`GBP_RECOVERY_CYC);
            end
          end else begin
            st_next.cnt = st_reg.cnt - 17'h00001;
          end
        end
        gbp_pkg::GBP_RECOVER: begin
          if (st_reg.cnt > 17'h00001) begin
            st_next.cnt = st_reg.cnt - 17'h00001;
          end else if (st_reg.dir == gbp_pkg::GBP_DIR_READ) begin
            st_next.phase = gbp_pkg::GBP_RD_LOW;
            st_next.cnt = period_ticks(st_reg.tim);
          end else begin
            st_next.drive = 1'b0;
            st_next.phase = gbp_pkg::GBP_IDLE;
            st_next.cycle_busy_flag = 1'b0;
          end
        end
        gbp_pkg::GBP_RD_HOLD: begin
        end
        default: begin
          st_next.phase = gbp_pkg::GBP_IDLE;
        end
      endcase
    end

    // ---------------------------------------------
    // Register writes
    // ---------------------------------------------
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'h0;
      if (hits(st_reg.aw_addr, `GBP_CTRL_OFFS)) begin
        if (st_reg.w_strb[0]) begin
          st_next.tim = st_reg.w_data[`GBP_TIM_HI:`GBP_TIM_LO];
          st_next.en = st_reg.w_data[`GBP_EN_BIT];
          if (st_reg.w_data[`GBP_DTA_BIT]) begin
            st_next.dma_transfer_active_flag = 1'b1;
          end
        end
      end else if (hits(st_reg.aw_addr, `GBP_DATA_OFFS)) begin
        if (st_reg.w_strb[0]) begin
          // Latches follow even with the port stopped
          st_next.latch = st_reg.w_data[7:0];
          st_next.dma_acknowledge = 1'b1;
          st_next.seq = 1'b1;
          if (st_reg.en && st_reg.tim != 4'h0) begin
            st_next.cycle_busy_flag = 1'b1;
            st_next.drive = 1'b1;
            st_next.phase = gbp_pkg::GBP_WR_LOW;
            st_next.dir = gbp_pkg::GBP_DIR_WRITE;
            st_next.cnt = period_ticks(st_reg.tim);
          end
        end
      end else begin
        st_next.bresp = 2'h2;
      end
    end

    // ---------------------------------------------
    // Register reads
    // ---------------------------------------------
    if (rd_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'h0;
      st_next.rdata = 32'h00000000;
      if (hits(s_axi_araddr, `GBP_CTRL_OFFS)) begin
        st_next.rdata[7:0] = {st_reg.tim, st_reg.en, st_reg.cycle_busy_flag, st_reg.seq, st_reg.dma_transfer_active_flag};
      end else if (data_rd) begin
        st_next.rdata[7:0] = st_reg.rd_capt;
        st_next.dma_acknowledge = 1'b1;
        st_next.seq = 1'b1;
        // Each data read launches the next read cycle when enabled
        if (st_reg.en && st_reg.tim != 4'h0) begin
          st_next.cycle_busy_flag = 1'b1;
          st_next.drive = 1'b0;
          st_next.dir = gbp_pkg::GBP_DIR_READ;
          st_next.phase = gbp_pkg::GBP_RD_LOW;
          st_next.cnt = period_ticks(st_reg.tim);
          if (!read_strobe_n) begin
            // Strobe still low from the last read: one high tick before it falls again
            st_next.phase = gbp_pkg::GBP_RECOVER;
            st_next.cnt = 17'(`GBP_RECOVERY_CYC);
          end
        end else begin
          st_next.phase = gbp_pkg::GBP_IDLE;
        end
      end else begin
        st_next.rresp = 2'h2;
      end
    end

    // Done pulse wins over a same-cycle access: it marks sequence end
    if (dma_done_interrupt) begin
      st_next.seq = 1'b0;
      st_next.dma_transfer_active_flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign low_nibble_port_latch = st_reg.latch[3:0];
  assign high_nibble_port_latch = st_reg.latch[7:4];
  assign ext_data_oe = {8{st_reg.drive}};
  assign write_strobe_n = (st_reg.phase != gbp_pkg::GBP_WR_LOW);
  assign read_strobe_n = !(st_reg.phase == gbp_pkg::GBP_RD_LOW || st_reg.phase == gbp_pkg::GBP_RD_HOLD);
  assign channel_dma_acknowledge = st_reg.dma_acknowledge;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_ctrl_reset_zero: assert property (@(posedge clk) $fell(sys_rst) |-> st_reg.tim == 4'h0 && !st_reg.dma_transfer_active_flag)
    else $error("control not zero after reset");
  a_wr_latch_update: assert property (@(posedge clk) disable iff (sys_rst) ce && data_wr |=> st_reg.latch == $past(st_reg.w_data[7:0]))
    else $error("latch not updated by data write");
  a_dma_acknowledge_on_access: assert property (@(posedge clk) disable iff (sys_rst) ce && (data_wr || data_rd) |=> channel_dma_acknowledge)
    else $error("missing acknowledge");
  a_no_strobe_disabled: assert property (@(posedge clk) disable iff (sys_rst) !st_reg.en && st_reg.phase == gbp_pkg::GBP_IDLE |=> write_strobe_n)
    else $error("strobe while disabled");
  a_busy_on_write: assert property (@(posedge clk) disable iff (sys_rst) ce && data_wr && st_reg.en && st_reg.tim != 4'h0 |=> st_reg.cycle_busy_flag && !write_strobe_n)
    else $error("busy or strobe not raised by write");
  a_done_clears_seq: assert property (@(posedge clk) disable iff (sys_rst) ce && dma_done_interrupt |=> !st_reg.seq && !st_reg.dma_transfer_active_flag)
    else $error("done did not clear flags");
  a_dta_set_one: assert property (@(posedge clk) disable iff (sys_rst) ce && !dma_done_interrupt && wr_fire && hits(st_reg.aw_addr, `GBP_CTRL_OFFS) && st_reg.w_strb[0] && st_reg.w_data[`GBP_DTA_BIT] |=> st_reg.dma_transfer_active_flag)
    else $error("transfer flag not set");
  a_strobe_recovery: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(write_strobe_n) |-> (write_strobe_n && read_strobe_n) [*4])
    else $error("strobes overlap");
  a_read_gap: assert property (@(posedge clk) disable iff (sys_rst) $rose(read_strobe_n) |-> read_strobe_n [*4])
    else $error("read strobe high too short");
  a_period_load: assert property (@(posedge clk) disable iff (sys_rst)
    ce && data_wr && cyc_start |=> st_reg.cnt == (17'h00001 << ($past(st_reg.tim) + 1)))
    else $error("strobe period not loaded");
  a_tim_zero_stops: assert property (@(posedge clk) disable iff (sys_rst) ce && st_reg.tim == 4'h0 && !data_rd && !data_wr |=> write_strobe_n && read_strobe_n)
    else $error("strobe with zero timing");
  a_latch_when_off: assert property (@(posedge clk) disable iff (sys_rst) ce && data_wr && st_reg.tim == 4'h0 |=> st_reg.latch == $past(st_reg.w_data[7:0]) && !st_reg.cycle_busy_flag)
    else $error("latch not updated while off");
endmodule

// File: verification/gbp_lcd_model.sv
/*
  Display driver model: byte RAM behind one auto-incrementing address counter.
  Assumes the bench resolves the shared data bus from both drivers.
*/
`timescale 1ns/1ps

module gbp_lcd_model (
  input wire logic sys_rst,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out
);
  logic [7:0] mem [0:15];
  logic [3:0] addr_reg;
  initial begin
    addr_reg = 4'h0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'h5A ^ 8'(i);
    end
  end
  // Byte taken as the strobe returns high, then the counter steps
  always @(posedge write_strobe_n) begin
    if (!sys_rst) begin
      mem[addr_reg] = bus_in;
      addr_reg = addr_reg + 4'h1;
    end
  end
  always @(posedge read_strobe_n) begin
    if (!sys_rst) begin
      addr_reg = addr_reg + 4'h1;
    end
  end
  // Released bus shows the inverse, so a stale byte never passes
  assign bus_out = read_strobe_n ? ~mem[addr_reg] : mem[addr_reg];
endmodule

// File: verification/gbp_graphic_port_bench.sv
/*
  Self-checking bench: register access, strobe timing, traffic to the display driver.
  Assumes the design under hw/ and the display driver model.
*/
`timescale 1ns/1ps
`include "gbp_cfg.svh"

module gbp_graphic_port_bench;
  localparam int DIV = `GBP_IO_DIV;
  localparam logic [7:0] CT = `GBP_CTRL_OFFS;
  localparam logic [7:0] DT = `GBP_DATA_OFFS;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, dma_done_interrupt = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, low_nibble_port_latch, high_nibble_port_latch;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic channel_dma_acknowledge, write_strobe_n, read_strobe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] ext_data_in, ext_data_oe, lcd_out;
  int err_total = 0, check_count = 0, dma_acknowledge_n = 0, wr_falls = 0;
  int wr_low = 0, wr_high = 0, last_low = 0, min_high = 999, oe_bad = 0;

  always #4 clk = ~clk;
  assign ext_data_in = (ext_data_oe & {high_nibble_port_latch, low_nibble_port_latch}) |
    (~ext_data_oe & lcd_out);

  gbp_graphic_port dut_u (.clk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dma_done_interrupt, .channel_dma_acknowledge, .ext_data_in, .low_nibble_port_latch,
    .high_nibble_port_latch, .ext_data_oe, .write_strobe_n, .read_strobe_n);
  gbp_lcd_model lcd_u (.sys_rst, .write_strobe_n, .read_strobe_n, .bus_in(ext_data_in), .bus_out(lcd_out));

  // Strobe watcher: low time of the last write strobe, shortest high gap
  always @(posedge clk) begin
    if (channel_dma_acknowledge === 1'b1) dma_acknowledge_n++;
    if (write_strobe_n === 1'b0) begin
      if (ext_data_oe !== 8'hFF) oe_bad++;
      if (wr_high != 0) wr_falls++;
      if (wr_high != 0 && wr_high < min_high) min_high = wr_high;
      wr_high = 0;
      wr_low++;
    end else begin
      if (wr_low != 0) last_low = wr_low;
      wr_low = 0;
      wr_high++;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] r;
    wr(a, {24'h0, v}, r);
    check("write response", {30'h0, r}, 32'h0);
  endtask

  task automatic get(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    v = d[7:0];
    check("read response", {30'h0, r}, 32'h0);
  endtask

  task automatic wait_idle;
    logic [7:0] c;
    int n;
    n = 0;
    do begin
      get(CT, c);
      n++;
    end while (c[`GBP_BSY_BIT] !== 1'b0 && n < 100);
    check("busy clears", {31'h0, c[`GBP_BSY_BIT]}, 32'h0);
  endtask

  // Done pulse, then both DMA flags must read zero
  task automatic finish_seq;
    logic [7:0] c;
    @(posedge clk);
    dma_done_interrupt <= 1'b1;
    @(posedge clk);
    dma_done_interrupt <= 1'b0;
    get(CT, c);
    check("dma flags cleared", {30'h0, c[1:0]}, 32'h0);
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] c;
    get(CT, c);
    check("control reset", {24'h0, c}, {24'h0, `GBP_CTRL_RESET});
    check("strobes idle", {30'h0, write_strobe_n, read_strobe_n}, 32'h3);
    rd(8'h08, d, r);
    check("unmapped response", {30'h0, r}, 32'h2);
    $display("test_reset done");
  endtask

  // Timing field zero, then enable clear: latches move, no strobe
  task automatic test_disabled;
    logic [7:0] cfg [2] = '{8'h08, 8'h10};
    logic [7:0] b, c;
    int k, f;
    for (int i = 0; i < 2; i++) begin
      b = 8'h3C + 8'(i);
      put(CT, cfg[i]);
      k = dma_acknowledge_n;
      f = wr_falls;
      put(DT, b);
      repeat (5 * DIV) @(posedge clk);
      check("latch byte", {24'h0, high_nibble_port_latch, low_nibble_port_latch}, {24'h0, b});
      check("acknowledge", 32'(dma_acknowledge_n - k), 32'h1);
      check("no strobe", 32'(wr_falls - f), 32'h0);
      get(CT, c);
      check("busy stays low", {31'h0, c[`GBP_BSY_BIT]}, 32'h0);
      finish_seq;
    end
    $display("test_disabled done");
  endtask

  task automatic test_write;
    logic [7:0] b, c;
    for (int t = 1; t < 4; t++) begin
      b = 8'hA0 + 8'(t);
      put(CT, {4'(t), 4'h8});
      put(DT, b);
      get(CT, c);
      check("busy and sequence", {30'h0, c[2:1]}, 32'h3);
      wait_idle;
      check("strobe low time", 32'(last_low), 32'((2 << t) * DIV));
      check("driver byte", {24'h0, lcd_u.mem[t - 1]}, {24'h0, b});
      finish_seq;
    end
    check("bus driven", 32'(oe_bad), 32'h0);
    check("strobe high gap", 32'(min_high >= DIV), 32'h1);
    $display("test_write done");
  endtask

  task automatic test_dma_write;
    logic [7:0] c;
    put(CT, 8'h19);
    get(CT, c);
    check("transfer flag set", {31'h0, c[0]}, 32'h1);
    put(CT, 8'h18);
    get(CT, c);
    check("zero write ignored", {31'h0, c[0]}, 32'h1);
    put(DT, 8'h77);
    wait_idle;
    check("driver byte", {24'h0, lcd_u.mem[3]}, 32'h77);
    finish_seq;
    $display("test_dma_write done");
  endtask

  // Dummy read, then enable cleared before the final read
  task automatic test_read;
    logic [7:0] v;
    int k;
    put(CT, 8'h18);
    k = dma_acknowledge_n;
    get(DT, v);
    wait_idle;
    check("read strobe held", {31'h0, read_strobe_n}, 32'h0);
    put(CT, 8'h10);
    get(DT, v);
    check("read byte", {24'h0, v}, {24'h0, 8'h5A ^ 8'h04});
    repeat (2) @(posedge clk);
    check("read acknowledges", 32'(dma_acknowledge_n - k), 32'h2);
    check("read strobe released", {31'h0, read_strobe_n}, 32'h1);
    finish_seq;
    $display("test_read done");
  endtask

  // DMA read: flag, dummy read, then reads as the DMA controller makes them
  task automatic test_dma_read;
    logic [7:0] v, c;
    put(CT, 8'h19);
    get(DT, v);
    wait_idle;
    get(DT, v);
    check("dma read byte", {24'h0, v}, {24'h0, 8'h5A ^ 8'h05});
    wait_idle;
    put(CT, 8'h10);
    get(DT, v);
    check("byte after strobe gap", {24'h0, v}, {24'h0, 8'h5A ^ 8'h06});
    get(CT, c);
    check("transfer flag held", {31'h0, c[0]}, 32'h1);
    finish_seq;
    $display("test_dma_read done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset;
    test_disabled;
    test_write;
    test_dma_write;
    test_read;
    test_dma_read;
    end_of_test;
  end

  // Tests need about 500 cycles; the 20000-cycle limit leaves wide margin
  initial begin
    #(8 * 20000);
    err_total++;
    end_of_test;
  end
endmodule
